// [verilog/fltsdm_pkg.sv]
/*
  Constants and carrier types shared by the fast-lock, resync and
  sigma-delta interpolator logic.
  Assumes the whole block runs on the phase detector clock.
*/
`default_nettype none

package fltsdm_pkg;

  // ********************************************************************
  // Serial word layout
  // ********************************************************************
  localparam int          WORD_W      = 32;
  localparam int          ADDR_HI     = 2;
  localparam logic [2:0]  ADDR_FREQ   = 3'h0;
  localparam logic [2:0]  ADDR_FRACT  = 3'h1;
  localparam logic [2:0]  ADDR_SPUR   = 3'h2;
  localparam logic [2:0]  ADDR_MODE   = 3'h3;
  localparam int          FIELD_LO    = 3;
  localparam int          FIELD_HI    = 14;
  localparam int          INT_LO      = 15;
  localparam int          INT_HI      = 30;
  localparam int          PHASE_LO    = 15;
  localparam int          PHASE_HI    = 26;
  localparam int          MODE_LO     = 15;
  localparam int          MODE_HI     = 16;
  localparam int          DITHER_LO   = 29;
  localparam int          DITHER_HI   = 30;
  localparam logic [1:0]  DITHER_ON   = 2'h3;

  // ********************************************************************
  // Modes, scales, reset values
  // ********************************************************************
  localparam logic [1:0]  MODE_FAST   = 2'h1;
  localparam logic [1:0]  MODE_RESYNC = 2'h2;
  localparam logic [4:0]  CP_NORMAL   = 5'h01;
  localparam logic [4:0]  CP_FAST     = 5'h10;
  localparam logic [15:0] INT_RST     = 16'h0017;
  localparam logic [11:0] FRAC_RST    = 12'h000;
  localparam logic [11:0] PHASE_RST   = 12'h001;
  localparam logic [11:0] DENOM_RST   = 12'h002;
  localparam logic [1:0]  MODE_RST    = 2'h0;
  localparam logic [11:0] CDIV_RST    = 12'h001;
  localparam int          LFSR_W      = 21;
  localparam logic [20:0] LFSR_SEED   = 21'h000001;
  localparam int          LFSR_TAP_A  = 20;
  localparam int          LFSR_TAP_B  = 18;

  // ********************************************************************
  // Carrier types
  // ********************************************************************
  typedef struct packed {
    logic [15:0] int_value;
    logic [11:0] frac;
    logic [11:0] phase_word;
    logic [11:0] fraction_denominator;
    logic [1:0]  divider_mode_field;
    logic [11:0] divider_count_field;
    logic        dither;
  } fltsdm_cfg_type;

  typedef struct packed {
    logic        carry;
    logic [11:0] sum;
  } fltsdm_acc_type;

  typedef enum logic [2:0] {
    RS_IDLE  = 3'b001,
    RS_WAIT1 = 3'b010,
    RS_WAIT2 = 3'b100
  } fltsdm_rs_type;

endpackage : fltsdm_pkg

`default_nettype wire

// [verilog/fltsdm_interp.sv]
/*
  Third-order MASH sigma-delta fractional interpolator.
  Assumes one advance per phase detector cycle and a fraction
  denominator from 2 up; load is a one-cycle pulse.
*/
`default_nettype none

module fltsdm_interp (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [11:0] frac,
  input  wire logic [11:0] denom,
  input  wire logic [11:0] seed,
  input  wire logic        dither,
  output var  logic [3:0]  code
);

  typedef struct packed {
    logic [11:0] a1;
    logic [11:0] a2;
    logic [11:0] a3;
    logic        c2_z;
    logic        c3_z;
    logic        c3_zz;
    logic [20:0] lfsr;
    logic [3:0]  code;
  } fltsdm_stage_type;

  fltsdm_stage_type s_q;
  fltsdm_stage_type s_d;

  // Modulo add; inputs stay below denom so one subtract suffices
  function automatic fltsdm_pkg::fltsdm_acc_type acc_step(
    input logic [11:0] acc,
    input logic [12:0] add,
    input logic [11:0] m
  );
    fltsdm_pkg::fltsdm_acc_type r;
    logic [13:0] t;
    t = {2'h0, acc} + {1'b0, add};
    if (t >= {2'h0, m}) begin
      t = t - {2'h0, m};
      r.carry = 1'b1;
    end else begin
      r.carry = 1'b0;
    end
    r.sum = t[11:0];
    return r;
  endfunction : acc_step

  fltsdm_pkg::fltsdm_acc_type st1;
  fltsdm_pkg::fltsdm_acc_type st2;
  fltsdm_pkg::fltsdm_acc_type st3;
  logic [12:0]                in1;
  logic signed [4:0]          y;

  always_comb begin
    s_d = s_q;
    in1 = {1'b0, frac} + {12'h000, dither & s_q.lfsr[0]};
    st1 = acc_step(s_q.a1, in1, denom);
    st2 = acc_step(s_q.a2, {1'b0, st1.sum}, denom);
    st3 = acc_step(s_q.a3, {1'b0, st2.sum}, denom);
    y = $signed({4'h0, st1.carry})
      + $signed({4'h0, st2.carry}) - $signed({4'h0, s_q.c2_z})
      + $signed({4'h0, st3.carry}) - $signed({3'h0, s_q.c3_z, 1'b0})
      + $signed({4'h0, s_q.c3_zz});
    s_d.a1    = st1.sum;
    s_d.a2    = st2.sum;
    s_d.a3    = st3.sum;
    s_d.c2_z  = st2.carry;
    s_d.c3_z  = st3.carry;
    s_d.c3_zz = s_q.c3_z;
    s_d.code  = y[3:0];
    s_d.lfsr  = {s_q.lfsr[19:0],
                 s_q.lfsr[fltsdm_pkg::LFSR_TAP_A]
                 ^ s_q.lfsr[fltsdm_pkg::LFSR_TAP_B]};
    if (load) begin
      s_d.a1    = seed;
      s_d.a2    = 12'h000;
      s_d.a3    = 12'h000;
      s_d.c2_z  = 1'b0;
      s_d.c3_z  = 1'b0;
      s_d.c3_zz = 1'b0;
      s_d.lfsr  = fltsdm_pkg::LFSR_SEED;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.lfsr <= fltsdm_pkg::LFSR_SEED;
    end else begin
      s_q <= s_d;
    end
  end

  assign code = s_q.code;

endmodule : fltsdm_interp

`default_nettype wire

// [verilog/fltsdm_top.sv]
/*
  Phase-detector-clocked control of a fractional-N synthesizer:
  3-wire word capture, fast-lock timer, resync timer and interpolator.
  Assumes ref_clk is the phase detector clock and that the serial
  pins are slow against it, so they are synchronised and edge sampled.
*/
// Summary of operation
// - Mode 0,1 enables fast-lock, loads timer
// - Wide bandwidth lasts divider count cycles
// - Charge pump sixteen times during fast-lock
// - Switch pin grounded during wide bandwidth
// - Third-order interpolator, denominator 2 to 4095
// - Interpolator advances once per reference cycle
// - Undithered repeat set by denominator factors
// - Dither stretches repeat to 2^21 cycles
// - Undithered interpolator seeded by phase word
// - Mode 1,0 enables resync sync timer
// - Sync every count times denominator cycles
// - Resync denominator from fraction register
// - Realign on second sync after load
// - Phase word sets output phase offset
// - Shift 32 bits, latch on load_enable
`default_nettype none

module fltsdm_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        load_enable,
  output var  logic        fast_lock_switch_pin,
  output var  logic        fast_lock_active,
  output var  logic [4:0]  cp_current_scale,
  output var  logic        sync_pulse,
  output var  logic        phase_realign,
  output var  logic [15:0] int_value,
  output var  logic [11:0] phase_offset,
  output var  logic [3:0]  interp_code
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [1:0]                 sclk_s;
    logic [1:0]                 data_s;
    logic [1:0]                 ld_s;
    logic                       sclk_d;
    logic                       ld_d;
    logic [31:0]                shift;
    fltsdm_pkg::fltsdm_cfg_type cfg;
    logic                       freq_load;
    logic [11:0]                fl_cnt;
    logic                       fl_act;
    logic                       fl_gnd;
    logic [4:0]                 cp_scale;
    logic [23:0]                rs_cnt;
    logic                       sync;
    fltsdm_pkg::fltsdm_rs_type  rs_st;
    logic                       realign;
  } fltsdm_top_type;

  fltsdm_top_type s_q;
  fltsdm_top_type s_d;

  logic        ld_rise;
  logic [2:0]  addr;
  logic [23:0] rs_period;
  logic        rs_on;

  always_comb begin
    s_d = s_q;
    // Second stage feeds the edge logic and the shift data
    s_d.sclk_s = {s_q.sclk_s[0], ser_clk};
    s_d.data_s = {s_q.data_s[0], ser_data};
    s_d.ld_s   = {s_q.ld_s[0], load_enable};
    s_d.sclk_d = s_q.sclk_s[1];
    s_d.ld_d   = s_q.ld_s[1];
    s_d.freq_load = 1'b0;
    s_d.sync      = 1'b0;
    s_d.realign   = 1'b0;
    ld_rise = s_q.ld_s[1] & ~s_q.ld_d;
    addr    = s_q.shift[fltsdm_pkg::ADDR_HI:0];

    // ******************************************************************
    // Serial capture
    // ******************************************************************
    // Shift on rising serial clock
    if (s_q.sclk_s[1] && !s_q.sclk_d) begin
      s_d.shift = {s_q.shift[30:0], s_q.data_s[1]};
    end
    if (ld_rise) begin
      case (addr)
        fltsdm_pkg::ADDR_FREQ: begin
          s_d.cfg.int_value =
            s_q.shift[fltsdm_pkg::INT_HI:fltsdm_pkg::INT_LO];
          s_d.cfg.frac =
            s_q.shift[fltsdm_pkg::FIELD_HI:fltsdm_pkg::FIELD_LO];
          s_d.freq_load = 1'b1;
        end
        fltsdm_pkg::ADDR_FRACT: begin
          s_d.cfg.fraction_denominator =
            s_q.shift[fltsdm_pkg::FIELD_HI:fltsdm_pkg::FIELD_LO];
          s_d.cfg.phase_word =
            s_q.shift[fltsdm_pkg::PHASE_HI:fltsdm_pkg::PHASE_LO];
        end
        fltsdm_pkg::ADDR_SPUR: begin
          s_d.cfg.dither =
            (s_q.shift[fltsdm_pkg::DITHER_HI:fltsdm_pkg::DITHER_LO]
             == fltsdm_pkg::DITHER_ON);
        end
        fltsdm_pkg::ADDR_MODE: begin
          s_d.cfg.divider_mode_field =
            s_q.shift[fltsdm_pkg::MODE_HI:fltsdm_pkg::MODE_LO];
          s_d.cfg.divider_count_field =
            s_q.shift[fltsdm_pkg::FIELD_HI:fltsdm_pkg::FIELD_LO];
        end
        default: begin
          // Other latches belong to the analog side
        end
      endcase
    end

    // ******************************************************************
    // Fast-lock timer
    // ******************************************************************
    // Count down once per reference cycle
    if (s_q.fl_act) begin
      if (s_q.fl_cnt <= 12'h001) begin
        s_d.fl_act = 1'b0;
        s_d.fl_cnt = 12'h000;
      end else begin
        s_d.fl_cnt = s_q.fl_cnt - 12'h001;
      end
    end
    if (s_q.freq_load
        && s_q.cfg.divider_mode_field == fltsdm_pkg::MODE_FAST
        && s_q.cfg.divider_count_field != 12'h000) begin
      s_d.fl_act = 1'b1;
      s_d.fl_cnt = s_q.cfg.divider_count_field;
    end
    // Leaving fast-lock mode drops wide bandwidth at once
    if (s_q.cfg.divider_mode_field != fltsdm_pkg::MODE_FAST) begin
      s_d.fl_act = 1'b0;
    end
    s_d.fl_gnd = s_d.fl_act;
    s_d.cp_scale = s_d.fl_act ? fltsdm_pkg::CP_FAST
                              : fltsdm_pkg::CP_NORMAL;

    // ******************************************************************
    // Resync timer
    // ******************************************************************
    // Period is count times denominator
    rs_period = 24'(s_q.cfg.divider_count_field
                    * s_q.cfg.fraction_denominator);
    rs_on = (s_q.cfg.divider_mode_field == fltsdm_pkg::MODE_RESYNC)
            && (rs_period != 24'h000000);
    if (!rs_on) begin
      s_d.rs_cnt = 24'h000000;
      s_d.rs_st  = fltsdm_pkg::RS_IDLE;
    end else begin
      if (s_q.rs_cnt >= rs_period - 24'h000001) begin
        s_d.rs_cnt = 24'h000000;
        s_d.sync   = 1'b1;
      end else begin
        s_d.rs_cnt = s_q.rs_cnt + 24'h000001;
      end
      case (s_q.rs_st)
        fltsdm_pkg::RS_IDLE: begin
          if (s_q.freq_load) begin
            s_d.rs_st = fltsdm_pkg::RS_WAIT1;
          end
        end
        fltsdm_pkg::RS_WAIT1: begin
          if (s_q.sync) begin
            s_d.rs_st = fltsdm_pkg::RS_WAIT2;
          end
        end
        fltsdm_pkg::RS_WAIT2: begin
          if (s_q.sync) begin
            s_d.realign = 1'b1;
            s_d.rs_st   = fltsdm_pkg::RS_IDLE;
          end
        end
        default: begin
          s_d.rs_st = fltsdm_pkg::RS_IDLE;
        end
      endcase
      // A newer load restarts the two-pulse wait
      if (s_q.freq_load) begin
        s_d.rs_st = fltsdm_pkg::RS_WAIT1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.cfg.int_value            <= fltsdm_pkg::INT_RST;
      s_q.cfg.frac                 <= fltsdm_pkg::FRAC_RST;
      s_q.cfg.phase_word           <= fltsdm_pkg::PHASE_RST;
      s_q.cfg.fraction_denominator <= fltsdm_pkg::DENOM_RST;
      s_q.cfg.divider_mode_field   <= fltsdm_pkg::MODE_RST;
      s_q.cfg.divider_count_field  <= fltsdm_pkg::CDIV_RST;
      s_q.cp_scale                 <= fltsdm_pkg::CP_NORMAL;
      s_q.rs_st                    <= fltsdm_pkg::RS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************************
  // Interpolator
  // ********************************************************************
  // Undithered repeat follows denominator
  // Seed taken at each frequency load
  fltsdm_interp u_interp (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (s_q.freq_load),
    .frac    (s_q.cfg.frac),
    .denom   (s_q.cfg.fraction_denominator),
    .seed    (s_q.cfg.phase_word),
    .dither  (s_q.cfg.dither),
    .code    (interp_code)
  );

  assign fast_lock_switch_pin = s_q.fl_gnd;
  assign fast_lock_active     = s_q.fl_act;
  assign cp_current_scale     = s_q.cp_scale;
  assign sync_pulse           = s_q.sync;
  assign phase_realign        = s_q.realign;
  assign int_value            = s_q.cfg.int_value;
  assign phase_offset         = s_q.cfg.phase_word;

endmodule : fltsdm_top

`default_nettype wire

// [test/fltsdm_top_properties.sv]
/*
  Port properties of fltsdm_top.
  Assumes one ref_clk domain and async active-low rst_n.
*/
`default_nettype none

module fltsdm_top_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        load_enable,
  input wire logic        fast_lock_switch_pin,
  input wire logic        fast_lock_active,
  input wire logic [4:0]  cp_current_scale,
  input wire logic        sync_pulse,
  input wire logic        phase_realign,
  input wire logic [15:0] int_value,
  input wire logic [3:0]  interp_code
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Length of the current wide-bandwidth run
  logic [12:0] run_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 13'h0000;
    end else begin
      run_q <= fast_lock_active ? run_q + 13'h0001 : 13'h0000;
    end
  end

  sequence s_ld_quiet;
    (!load_enable)[*6];
  endsequence
  sequence s_realign_step;
    sync_pulse ##1 phase_realign;
  endsequence

  AST_CP_SCALE: assert property (
    cp_current_scale == (fast_lock_active ? fltsdm_pkg::CP_FAST
                                          : fltsdm_pkg::CP_NORMAL))
    else $error("cp scale");
  AST_SWITCH_PIN: assert property (
    fast_lock_switch_pin == fast_lock_active) else $error("switch pin");
  AST_FAST_BOUND: assert property (run_q <= 13'h0FFF)
    else $error("fast run too long");
  AST_FAST_CAUSE: assert property (
    $rose(fast_lock_active) |-> $past(load_enable, 3))
    else $error("fast rise");
  AST_MODES_APART: assert property (
    !(fast_lock_active && sync_pulse)) else $error("fast and sync");
  AST_SYNC_SINGLE: assert property (sync_pulse |=> !sync_pulse)
    else $error("sync width");
  AST_REALIGN_CAUSE: assert property (
    phase_realign |-> $past(sync_pulse)) else $error("realign cause");
  AST_REALIGN_SINGLE: assert property (
    phase_realign |=> !phase_realign) else $error("realign width");
  AST_CODE_RANGE: assert property (
    !(interp_code inside {4'h8, 4'h9, 4'hA, 4'hB, 4'hC}))
    else $error("code range");
  AST_INT_HOLD: assert property (s_ld_quiet |=> $stable(int_value))
    else $error("int moved");
  COV_REALIGN: cover property (s_realign_step);
endmodule : fltsdm_top_checker

bind fltsdm_top fltsdm_top_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .load_enable(load_enable),
  .fast_lock_switch_pin(fast_lock_switch_pin),
  .fast_lock_active(fast_lock_active), .cp_current_scale(cp_current_scale),
  .sync_pulse(sync_pulse), .phase_realign(phase_realign),
  .int_value(int_value), .interp_code(interp_code));

`default_nettype wire

// [test/fltsdm_host.sv]
/*
  Host controller model: shifts 32-bit words over the 3-wire port.
  Assumes the caller picks legal field values.
*/
`default_nettype none

module fltsdm_host (
  input  wire logic ref_clk,
  output var  logic ser_clk,
  output var  logic ser_data,
  output var  logic load_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_enable = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic write_word(input logic [31:0] w, input int hp);
    for (int i = 31; i >= 0; i--) begin
      ser_data = w[i];
      tick(hp);
      ser_clk = 1'b1;
      tick(hp);
      ser_clk = 1'b0;
    end
    // Released data line must not echo the last bit
    ser_data = ~w[0];
    load_enable = 1'b1;
    tick(8);
    load_enable = 1'b0;
    tick(4);
  endtask : write_word
endmodule : fltsdm_host

`default_nettype wire

// [test/tb_top.sv]
/*
  Self-checking bench for fltsdm_top.
  Assumes fltsdm_host drives the serial pins.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic sck, sdat, lden;
  logic fsw, fla, syn, rea;
  logic [4:0] cps;
  logic [15:0] iv_o;
  logic [11:0] ph_o;
  logic [3:0] code;
  int err_total = 0;
  int checks = 0;
  integer seed = 32'hB5F3D86A;
  logic [31:0] q_fast[$], q_sync[$], q_real[$], q_int[$];
  int run_len = 0, gap = 0, n_sync = 0;
  bit skip_sync = 0;
  logic [15:0] last_int = 16'h0017;

  always #10 ref_clk = ~ref_clk;
  fltsdm_host host (.ref_clk(ref_clk), .ser_clk(sck), .ser_data(sdat),
    .load_enable(lden));
  fltsdm_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .ser_clk(sck),
    .ser_data(sdat), .load_enable(lden), .fast_lock_switch_pin(fsw),
    .fast_lock_active(fla), .cp_current_scale(cps), .sync_pulse(syn),
    .phase_realign(rea), .int_value(iv_o), .phase_offset(ph_o),
    .interp_code(code));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ******************************************************************
  // Output watcher
  // ******************************************************************
  // Design counts syncs from one edge after its own latch: sync depth plus two edges
  always @(posedge lden) begin
    repeat (4) @(posedge ref_clk);
    n_sync = 0;
  end
  always @(negedge ref_clk) begin
    if (rst_n) begin
      gap++;
      if (fla === 1'b1) begin
        run_len++;
      end else if (run_len > 0) begin
        chk(run_len, q_fast.size() ? q_fast.pop_front() : 0);
        run_len = 0;
      end
      if (syn === 1'b1) begin
        n_sync++;
        if (!skip_sync && q_sync.size() > 0) begin
          chk(gap, q_sync.pop_front());
        end
        skip_sync = 0;
        gap = 0;
      end
      if (rea === 1'b1) begin
        chk(n_sync, q_real.size() ? q_real.pop_front() : 0);
      end
      if (iv_o !== last_int) begin
        chk(iv_o, q_int.size() ? q_int.pop_front() : last_int);
        last_int = iv_o;
      end
    end
  end

  // ******************************************************************
  // Stimulus helpers
  // ******************************************************************
  task automatic wr(input logic [2:0] a, input logic [28:0] body);
    host.write_word({body, a}, 3 + ($unsigned($random(seed)) % 4));
  endtask : wr
  task automatic freq(input logic [11:0] frac);
    logic [15:0] v;
    v = 16'($random(seed));
    if (v === last_int) v = ~v;
    q_int.push_back(v);
    wr(3'h0, {1'b0, v, frac});
  endtask : freq
  task automatic drain;
    for (int n = 0; q_fast.size() + q_sync.size() + q_real.size()
         + q_int.size() != 0; n++) begin
      @(posedge ref_clk);
      if (n > 20000) begin
        chk(0, 1);
        end_of_test();
      end
    end
  endtask : drain
  task automatic scan(input int l, output logic [31:0] s, output int d);
    logic [3:0] c[$];
    s = 32'h0;
    d = 0;
    repeat (20) @(negedge ref_clk);
    repeat (2 * l) @(negedge ref_clk) c.push_back(code);
    for (int i = 0; i < l; i++) begin
      s = s + {{28{c[i][3]}}, c[i]};
      if (c[i] !== c[i + l]) d++;
    end
  endtask : scan

  initial begin
    int mods[5] = '{2, 5, 9, 6, 4095};
    int m, l, d;
    logic [31:0] s;
    logic [11:0] ph;
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk(iv_o, fltsdm_pkg::INT_RST);
    chk(ph_o, fltsdm_pkg::PHASE_RST);
    chk(cps, fltsdm_pkg::CP_NORMAL);
    chk({fsw, fla, syn, rea}, 4'h0);
    chk(code, 4'h0);
    foreach (mods[k]) begin
      m = mods[k];
      l = (m % 6 == 0) ? 6 * m : (m % 3 == 0) ? 3 * m
        : (m % 2 == 0) ? 2 * m : m;
      ph = $unsigned($random(seed)) % m;
      wr(3'h1, {5'h00, ph, 12'(m)});
      chk(ph_o, ph);
      freq(12'h001);
      drain();
      scan(l, s, d);
      chk(s, l / m);
      chk(d, 0);
    end
    wr(3'h1, {5'h00, ph, 12'h032});
    wr(3'h2, {1'b0, 2'h3, 26'h0});
    freq(12'h001);
    scan(100, s, d);
    chk(d != 0, 1);
    wr(3'h2, 29'h0);
    for (int k = 0; k < 2; k++) begin
      l = k ? 2 + $unsigned($random(seed)) % 200 : 1;
      wr(3'h3, {15'h0, fltsdm_pkg::MODE_FAST, 12'(l)});
      q_fast.push_back(l);
      freq(12'h001);
      drain();
    end
    wr(3'h1, {5'h00, ph, 12'h005});
    skip_sync = 1;
    repeat (3) q_sync.push_back(35);
    wr(3'h3, {15'h0, fltsdm_pkg::MODE_RESYNC, 12'h007});
    drain();
    q_real.push_back(2);
    freq(12'h002);
    drain();
    wr(3'h3, 29'h0);
    // Unmapped address must change nothing
    wr(3'h4, 29'($random(seed)));
    chk(ph_o, ph);
    repeat (50) @(posedge ref_clk);
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
